// >>> rtl/cpu_register_file_status_stack.sv
// cpu datapath: register file, alu, fetch pipeline, status flags, interrupt entry and stack
`timescale 1ns/1ps
module cpu_register_file_status_stack
  import core_pkg::*;
#(
  parameter int NUM_IRQ = NUM_IRQ_DEF
)(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // program memory, read data one cycle after the address
  output logic [PC_W-1:0] pm_addr,
  input wire logic [15:0] pm_data,
  // data memory, read data one cycle after dm_re
  output logic [7:0] dm_addr,
  output logic [7:0] dm_wdata,
  output logic dm_we,
  output logic dm_re,
  input wire logic [7:0] dm_rdata,
  // interrupt requests, already masked per source
  input wire logic [NUM_IRQ-1:0] irq_req,
  output logic [NUM_IRQ-1:0] irq_ack,
  // state view
  output logic [7:0] status_flags_reg,
  output logic [7:0] stack_top_pointer
);
  localparam logic [NUM_IRQ-1:0] IRQ_ONE = NUM_IRQ'(1);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] alu(input alu_op_e op, input logic [7:0] a, input logic [7:0] b,
                                      input logic [7:0] s);
    logic [8:0] full;
    logic [4:0] half;
    logic [7:0] r;
    logic [7:0] f;
    logic [7:0] bb;
    logic cin;
    logic sub;
    logic arith;
    begin
      f = s;
      cin = (op == ALU_ADC || op == ALU_SBC) ? s[FLAG_C] : 1'b0;
      sub = (op == ALU_SUB || op == ALU_SBC || op == ALU_DEC);
      arith = (op <= ALU_SBC) || op == ALU_INC || op == ALU_DEC;
      bb = (op == ALU_INC || op == ALU_DEC) ? 8'h01 : b;
      if (sub)
      begin
        full = {1'b0, a} - {1'b0, bb} - {8'h00, cin};
        half = {1'b0, a[3:0]} - {1'b0, bb[3:0]} - {4'h0, cin};
      end
      else
      begin
        full = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
        half = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
      end
      r = full[7:0];
      case (op)
        ALU_AND: r = a & b;
        ALU_OR: r = a | b;
        ALU_XOR: r = a ^ b;
        ALU_PASS: r = b;
        ALU_COM: r = ~a;
        default: r = full[7:0];
      endcase
      if (op != ALU_PASS)
      begin
        f[FLAG_N] = r[7];
        // chained subtract keeps zero only if it was already zero
        f[FLAG_Z] = (op == ALU_SBC) ? (s[FLAG_Z] && r == 8'h00) : (r == 8'h00);
        f[FLAG_V] = arith && (sub ? (a[7] != bb[7]) : (a[7] == bb[7])) && (r[7] != a[7]);
        f[FLAG_S] = f[FLAG_N] ^ f[FLAG_V];
      end
      if (arith && op != ALU_INC && op != ALU_DEC)
      begin
        f[FLAG_H] = half[4];
        f[FLAG_C] = full[8];
      end
      if (op == ALU_COM)
        f[FLAG_C] = 1'b1;
      return {r, f};
    end
  endfunction

  function automatic logic [PC_W-1:0] vec_of(input logic [NUM_IRQ-1:0] req);
    logic [PC_W-1:0] v;
    begin
      v = VEC_FIRST;
      for (int i = NUM_IRQ - 1; i >= 0; i--)
        if (req[i])
          v = VEC_FIRST + PC_W'(i);
      return v;
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  core_state_e state_q, state_d;
  logic [PC_W-1:0] pc_q, pc_d, jump_q, jump_d, ret_pc;
  logic valid_q, valid_d;
  logic [15:0] ir_q, ir_d, ret_w, acc_addr;
  logic [7:0] gpr_q [GPR_COUNT];
  logic [7:0] gpr_d [GPR_COUNT];
  logic [7:0] status_flags_reg_q, status_flags_reg_d, sp_q, sp_d, hold_q, hold_d;
  logic [7:0] dm_addr_q, dm_addr_d, dm_wdata_q, dm_wdata_d, opb, acc_data;
  logic dm_we_q, dm_we_d, dm_re_q, dm_re_d;
  logic [NUM_IRQ-1:0] irq_ack_q, irq_ack_d;
  alu_op_e op;
  logic [4:0] dst, ptr_lo, acc_reg;
  logic [15:0] alu_res;
  logic alu_go, alu_wb, acc_ld, acc_st, imm_op;
  logic take_irq, take_call, take_ret, take_push, take_pop, st_reg;

  // decode fields of the word in execution
  logic [4:0] rd_f, rr_f, rdh_f;
  logic [7:0] k_f;
  logic [5:0] ioa_f;
  assign rd_f = pm_data[8:4];
  assign rr_f = {pm_data[9], pm_data[3:0]};
  assign rdh_f = {1'b1, pm_data[7:4]};
  assign k_f = {pm_data[11:8], pm_data[3:0]};
  assign ioa_f = {pm_data[10:9], pm_data[3:0]};
  assign take_irq = state_q == ST_EXEC && valid_q && status_flags_reg_q[FLAG_I] && irq_req != '0;
  assign ret_w = 16'(ret_pc);
  assign acc_reg = acc_addr[4:0];

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    state_d = state_q;
    pc_d = pc_q;
    valid_d = valid_q;
    ir_d = ir_q;
    gpr_d = gpr_q;
    status_flags_reg_d = status_flags_reg_q;
    sp_d = sp_q;
    hold_d = hold_q;
    jump_d = jump_q;
    dm_addr_d = dm_addr_q;
    dm_wdata_d = dm_wdata_q;
    dm_we_d = 1'b0;
    dm_re_d = 1'b0;
    irq_ack_d = '0;
    op = ALU_PASS;
    opb = gpr_q[rr_f];
    dst = rd_f;
    alu_go = 1'b0;
    alu_wb = 1'b1;
    alu_res = 16'h0000;
    acc_ld = 1'b0;
    acc_st = 1'b0;
    acc_addr = 16'h0000;
    acc_data = gpr_q[rd_f];
    ptr_lo = PTR_X_LO;
    imm_op = 1'b0;
    ret_pc = pc_q;
    take_call = 1'b0;
    take_ret = 1'b0;
    take_push = 1'b0;
    take_pop = 1'b0;
    st_reg = 1'b0;
    unique case (state_q)
      ST_EXEC:
      begin
        // fetch runs one word ahead; a cleared valid marks a flushed word
        pc_d = pc_q + 10'h001;
        valid_d = 1'b1;
        if (take_irq)
        begin
          ret_pc = pc_q - 10'h001;
          irq_ack_d = irq_req & (~irq_req + IRQ_ONE);
          status_flags_reg_d[FLAG_I] = 1'b0;
          jump_d = vec_of(irq_req);
          take_call = 1'b1;
        end
        else if (valid_q)
        begin
          casez (pm_data)
            16'b0000_11??_????_????: begin op = ALU_ADD; alu_go = 1'b1; end
            16'b0001_11??_????_????: begin op = ALU_ADC; alu_go = 1'b1; end
            16'b0001_10??_????_????: begin op = ALU_SUB; alu_go = 1'b1; end
            16'b0000_10??_????_????: begin op = ALU_SBC; alu_go = 1'b1; end
            16'b0001_01??_????_????: begin op = ALU_SUB; alu_go = 1'b1; alu_wb = 1'b0; end
            16'b0010_00??_????_????: begin op = ALU_AND; alu_go = 1'b1; end
            16'b0010_01??_????_????: begin op = ALU_XOR; alu_go = 1'b1; end
            16'b0010_10??_????_????: begin op = ALU_OR; alu_go = 1'b1; end
            16'b0010_11??_????_????: begin op = ALU_PASS; alu_go = 1'b1; end
            16'b0011_????_????_????: begin op = ALU_SUB; imm_op = 1'b1; alu_wb = 1'b0; end
            16'b0100_????_????_????: begin op = ALU_SBC; imm_op = 1'b1; end
            16'b0101_????_????_????: begin op = ALU_SUB; imm_op = 1'b1; end
            16'b0110_????_????_????: begin op = ALU_OR; imm_op = 1'b1; end
            16'b0111_????_????_????: begin op = ALU_AND; imm_op = 1'b1; end
            16'b1110_????_????_????: begin op = ALU_PASS; imm_op = 1'b1; end
            16'b1001_010?_????0000: begin op = ALU_COM; alu_go = 1'b1; end
            16'b1001_010?_????0011: begin op = ALU_INC; alu_go = 1'b1; end
            16'b1001_010?_????1010: begin op = ALU_DEC; alu_go = 1'b1; end
            16'h9478: status_flags_reg_d[FLAG_I] = 1'b1;
            16'h94f8: status_flags_reg_d[FLAG_I] = 1'b0;
            16'b1001_0101_000?_1000:
            begin
              take_ret = 1'b1;
              dm_re_d = 1'b1;
              dm_addr_d = sp_q + 8'h01;
              sp_d = sp_q + 8'h02;
              ir_d = pm_data;
              pc_d = pc_q;
              state_d = ST_RET_A;
            end
            16'b1001_001?_????_1111:
            begin
              take_push = 1'b1;
              dm_we_d = 1'b1;
              dm_addr_d = sp_q;
              dm_wdata_d = gpr_q[rd_f];
              sp_d = sp_q - 8'h01;
            end
            16'b1001_000?_????_1111:
            begin
              take_pop = 1'b1;
              sp_d = sp_q + 8'h01;
              dm_re_d = 1'b1;
              dm_addr_d = sp_q + 8'h01;
              ir_d = pm_data;
              pc_d = pc_q;
              state_d = ST_LOAD_A;
            end
            16'b1001_00??_????_1100, 16'b1000_00??_????_?000:
            begin
              if (pm_data[12])
                ptr_lo = PTR_X_LO;
              else
                ptr_lo = pm_data[3] ? PTR_Y_LO : PTR_Z_LO;
              acc_addr = {gpr_q[ptr_lo + 5'h01], gpr_q[ptr_lo]};
              acc_st = pm_data[9];
              acc_ld = !pm_data[9];
            end
            16'b1011_????_????_????:
            begin
              acc_addr = IO_BASE + {10'h000, ioa_f};
              acc_st = pm_data[11];
              acc_ld = !pm_data[11];
            end
            16'b1111_100?_????_0???: gpr_d[rd_f][pm_data[2:0]] = status_flags_reg_q[FLAG_T];
            16'b1111_101?_????_0???: status_flags_reg_d[FLAG_T] = gpr_q[rd_f][pm_data[2:0]];
            16'b1100_????_????_????:
            begin
              pc_d = pc_q + pm_data[PC_W-1:0];
              valid_d = 1'b0;
            end
            16'b1101_????_????_????:
            begin
              jump_d = pc_q + pm_data[PC_W-1:0];
              take_call = 1'b1;
            end
            default: ;
          endcase
          if (imm_op)
          begin
            alu_go = 1'b1;
            dst = rdh_f;
            opb = k_f;
          end
          if (alu_go)
          begin
            alu_res = alu(op, gpr_q[dst], opb, status_flags_reg_q);
            status_flags_reg_d = {status_flags_reg_q[7:6], alu_res[5:0]};
            if (alu_wb)
              gpr_d[dst] = alu_res[15:8];
          end
          if (acc_st || acc_ld)
          begin
            if (acc_addr < IO_BASE)
            begin
              st_reg = acc_st;
              if (acc_st)
                gpr_d[acc_reg] = acc_data;
              else
                gpr_d[rd_f] = gpr_q[acc_reg];
            end
            else if (acc_addr == SP_DADDR)
            begin
              if (acc_st)
                sp_d = acc_data;
              else
                gpr_d[rd_f] = sp_q;
            end
            else if (acc_addr == STATUS_FLAGS_REG_DADDR)
            begin
              if (acc_st)
                status_flags_reg_d = acc_data;
              else
                gpr_d[rd_f] = status_flags_reg_q;
            end
            else if (acc_addr < DATA_END)
            begin
              // other io and the sram lie outside on the data bus
              dm_addr_d = acc_addr[7:0];
              dm_wdata_d = acc_data;
              dm_we_d = acc_st;
              dm_re_d = acc_ld;
              if (acc_ld)
              begin
                ir_d = pm_data;
                pc_d = pc_q;
                state_d = ST_LOAD_A;
              end
            end
            else if (acc_ld)
              gpr_d[rd_f] = 8'h00;
          end
        end
        if (take_call)
        begin
          dm_we_d = 1'b1;
          dm_addr_d = sp_q;
          dm_wdata_d = ret_w[7:0];
          sp_d = sp_q - 8'h01;
          hold_d = ret_w[15:8];
          pc_d = pc_q;
          state_d = ST_CALL_B;
        end
      end
      ST_LOAD_A: state_d = ST_LOAD_B;
      ST_LOAD_B:
      begin
        gpr_d[ir_q[8:4]] = dm_rdata;
        // next word already sits in pm_data; step on so it is not fetched twice
        pc_d = pc_q + 10'h001;
        state_d = ST_EXEC;
      end
      ST_CALL_B:
      begin
        dm_we_d = 1'b1;
        dm_addr_d = sp_q;
        dm_wdata_d = hold_q;
        sp_d = sp_q - 8'h01;
        pc_d = jump_q;
        valid_d = 1'b0;
        state_d = ST_EXEC;
      end
      ST_RET_A:
      begin
        dm_re_d = 1'b1;
        dm_addr_d = sp_q;
        state_d = ST_RET_B;
      end
      ST_RET_B:
      begin
        hold_d = dm_rdata;
        state_d = ST_RET_C;
      end
      ST_RET_C:
      begin
        pc_d = PC_W'({hold_q, dm_rdata});
        valid_d = 1'b0;
        if (ir_q[4])
          status_flags_reg_d[FLAG_I] = 1'b1;
        state_d = ST_EXEC;
      end
      default: state_d = ST_EXEC;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_q <= ST_EXEC;
      pc_q <= PC_RESET;
      valid_q <= 1'b0;
      ir_q <= 16'h0000;
      for (int i = 0; i < GPR_COUNT; i++)
        gpr_q[i] <= GPR_RESET;
      status_flags_reg_q <= STATUS_FLAGS_REG_RESET;
      sp_q <= SP_RESET;
      hold_q <= 8'h00;
      jump_q <= PC_RESET;
      dm_addr_q <= 8'h00;
      dm_wdata_q <= 8'h00;
      dm_we_q <= 1'b0;
      dm_re_q <= 1'b0;
      irq_ack_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      pc_q <= pc_d;
      valid_q <= valid_d;
      ir_q <= ir_d;
      gpr_q <= gpr_d;
      status_flags_reg_q <= status_flags_reg_d;
      sp_q <= sp_d;
      hold_q <= hold_d;
      jump_q <= jump_d;
      dm_addr_q <= dm_addr_d;
      dm_wdata_q <= dm_wdata_d;
      dm_we_q <= dm_we_d;
      dm_re_q <= dm_re_d;
      irq_ack_q <= irq_ack_d;
    end
  end

  assign pm_addr = pc_q;
  assign dm_addr = dm_addr_q;
  assign dm_wdata = dm_wdata_q;
  assign dm_we = dm_we_q;
  assign dm_re = dm_re_q;
  assign irq_ack = irq_ack_q;
  assign status_flags_reg = status_flags_reg_q;
  assign stack_top_pointer = sp_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sign_rel_a: assert property (@(posedge clock) disable iff (srst)
    alu_go |=> status_flags_reg_q[FLAG_S] == (status_flags_reg_q[FLAG_N] ^ status_flags_reg_q[FLAG_V])) else $error("sign flag broken");
  irq_gate_a: assert property (@(posedge clock) disable iff (srst)
    irq_ack_q != '0 |-> $past(status_flags_reg_q[FLAG_I])) else $error("interrupt taken while disabled");
  irq_clear_a: assert property (@(posedge clock) disable iff (srst)
    take_irq |=> !status_flags_reg_q[FLAG_I] ##1 (pc_q == $past(jump_q)) && !valid_q) else $error("bad interrupt entry");
  irq_prio_a: assert property (@(posedge clock) disable iff (srst)
    take_irq |=> $onehot(irq_ack_q) && (((irq_ack_q - IRQ_ONE) & $past(irq_req)) == '0))
    else $error("interrupt priority wrong");
  call_sp_a: assert property (@(posedge clock) disable iff (srst)
    take_call |=> ##1 sp_q == $past(sp_q, 2) - 8'h02) else $error("call stack step wrong");
  ret_sp_a: assert property (@(posedge clock) disable iff (srst)
    take_ret |=> sp_q == $past(sp_q) + 8'h02 ##3 !valid_q) else $error("return stack step wrong");
  push_order_a: assert property (@(posedge clock) disable iff (srst)
    take_push |=> dm_we_q && dm_addr_q == $past(sp_q) && sp_q == $past(sp_q) - 8'h01)
    else $error("push order wrong");
  pop_order_a: assert property (@(posedge clock) disable iff (srst)
    take_pop |=> dm_re_q && dm_addr_q == sp_q && sp_q == $past(sp_q) + 8'h01) else $error("pop order wrong");
  upper_only_a: assert property (@(posedge clock) disable iff (srst)
    imm_op |-> dst >= UPPER_BASE) else $error("constant op below r16");
  fetch_step_a: assert property (@(posedge clock) disable iff (srst)
    alu_go |=> valid_q && pc_q == $past(pc_q) + 10'h001) else $error("fetch did not advance");
  reg_map_a: assert property (@(posedge clock) disable iff (srst)
    st_reg |=> !dm_we_q && gpr_q[$past(acc_reg)] == $past(acc_data)) else $error("register store missed");
endmodule

// >>> rtl/core_pkg.sv
// constants, field positions and types shared by the cpu register file, status and stack block
package core_pkg;
  localparam int GPR_COUNT = 32;
  localparam int PC_W = 10;
  localparam int NUM_IRQ_DEF = 8;
  localparam logic [4:0] PTR_X_LO = 5'h1a;
  localparam logic [4:0] PTR_Y_LO = 5'h1c;
  localparam logic [4:0] PTR_Z_LO = 5'h1e;
  localparam logic [4:0] UPPER_BASE = 5'h10;
  localparam logic [15:0] IO_BASE = 16'h0020;
  localparam logic [15:0] SRAM_BASE = 16'h0060;
  localparam logic [15:0] DATA_END = 16'h00e0;
  localparam logic [5:0] SP_IO_OFS = 6'h3d;
  localparam logic [5:0] STATUS_FLAGS_REG_IO_OFS = 6'h3f;
  localparam logic [15:0] SP_DADDR = IO_BASE + {10'h000, SP_IO_OFS};
  localparam logic [15:0] STATUS_FLAGS_REG_DADDR = IO_BASE + {10'h000, STATUS_FLAGS_REG_IO_OFS};
  localparam int FLAG_I = 7;
  localparam int FLAG_T = 6;
  localparam int FLAG_H = 5;
  localparam int FLAG_S = 4;
  localparam int FLAG_V = 3;
  localparam int FLAG_N = 2;
  localparam int FLAG_Z = 1;
  localparam int FLAG_C = 0;
  localparam logic [7:0] STATUS_FLAGS_REG_RESET = 8'h00;
  localparam logic [7:0] SP_RESET = 8'hdf;
  localparam logic [7:0] GPR_RESET = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 10'h000;
  localparam logic [PC_W-1:0] VEC_FIRST = 10'h001;

  typedef enum logic [3:0] {
    ALU_ADD = 4'h0, ALU_ADC = 4'h1, ALU_SUB = 4'h2, ALU_SBC = 4'h3,
    ALU_AND = 4'h4, ALU_OR = 4'h5, ALU_XOR = 4'h6, ALU_PASS = 4'h7,
    ALU_COM = 4'h8, ALU_INC = 4'h9, ALU_DEC = 4'ha
  } alu_op_e;

  typedef enum logic [2:0] {
    ST_EXEC = 3'b000, ST_LOAD_A = 3'b001, ST_LOAD_B = 3'b010, ST_CALL_B = 3'b011,
    ST_RET_A = 3'b100, ST_RET_B = 3'b101, ST_RET_C = 3'b110
  } core_state_e;
endpackage

// >>> test/mem_model.sv
// far-side model: program rom and data ram facing the core
`timescale 1ns/1ps
module mem_model
  import core_pkg::*;
(
  // clock
  input wire logic clock,
  // program bus
  input wire logic [PC_W-1:0] pm_addr,
  output logic [15:0] pm_data,
  // data bus
  input wire logic [7:0] dm_addr,
  input wire logic [7:0] dm_wdata,
  input wire logic dm_we,
  input wire logic dm_re,
  output logic [7:0] dm_rdata
);
  // ----
  // storage
  // ----
  logic [15:0] rom [0:1023];
  logic [7:0] ram [0:255];

  initial
  begin
    pm_data = 16'h0000;
    dm_rdata = 8'h00;
  end

  // dm_rdata valid one cycle only, then toggles so a late sample fails
  always @(posedge clock)
  begin
    pm_data <= rom[pm_addr];
    if (dm_we)
      ram[dm_addr] <= dm_wdata;
    dm_rdata <= dm_re ? ram[dm_addr] : ~dm_rdata;
  end
endmodule

// >>> test/tb_top.sv
// self-checking testbench for the cpu register file, status and stack block
`timescale 1ns/1ps
module tb_top;
  // ----
  // signals
  // ----
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [9:0] pm_addr;
  logic [15:0] pm_data;
  logic [7:0] dm_addr, dm_wdata, dm_rdata, status_flags_reg, stack_top_pointer;
  logic dm_we, dm_re;
  logic [7:0] irq_req = 8'h00;
  logic [7:0] irq_ack, ack_seen;
  int miscompares = 0;
  int n_checks = 0;

  always #5 clock = ~clock;

  cpu_register_file_status_stack cpu_register_file_status_stack_i (
    .clock(clock), .srst(srst), .pm_addr(pm_addr), .pm_data(pm_data),
    .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_re(dm_re),
    .dm_rdata(dm_rdata), .irq_req(irq_req), .irq_ack(irq_ack),
    .status_flags_reg(status_flags_reg), .stack_top_pointer(stack_top_pointer));

  mem_model mem_model_i (
    .clock(clock), .pm_addr(pm_addr), .pm_data(pm_data), .dm_addr(dm_addr),
    .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_re(dm_re), .dm_rdata(dm_rdata));

  // every source drops its request once any one is taken
  always @(posedge clock)
    if (irq_ack !== 8'h00)
    begin
      ack_seen <= irq_ack;
      irq_req <= 8'h00;
    end

  // ----
  // helpers
  // ----
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic load(input logic [15:0] p[$], input int base);
    if (base == 0)
      for (int i = 0; i < 1024; i++) mem_model_i.rom[i] = 16'h0000;
    foreach (p[i]) mem_model_i.rom[base + i] = p[i];
  endtask

  task automatic rst();
    @(posedge clock);
    srst <= 1'b1;
    for (int i = 0; i < 256; i++) mem_model_i.ram[i] = 8'h00;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
  endtask

  // bounded wait for a write (wr=1) or read strobe, sampled mid-cycle
  task automatic wait_bus(input logic wr, output logic [7:0] a, d, f, s);
    {a, d, f, s} = 'x;
    for (int k = 0; k < 60; k++)
    begin
      @(negedge clock);
      if ((wr ? dm_we : dm_re) === 1'b1)
      begin
        {a, d, f, s} = {dm_addr, dm_wdata, status_flags_reg, stack_top_pointer};
        break;
      end
    end
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_reset();
    logic [9:0] p;
    load('{16'h0000}, 0);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk(pm_addr[7:0], 8'h00);
    chk(status_flags_reg, 8'h00);
    chk(stack_top_pointer, 8'hdf);
    @(posedge clock);
    srst <= 1'b0;
    repeat (4) @(negedge clock);
    p = pm_addr;
    @(negedge clock);
    chk(pm_addr[7:0], p[7:0] + 8'h01);
    $display("reset test done");
  endtask

  // byte adds, constant subtract, pushes of upper and lower registers
  task automatic t_alu();
    logic [7:0] a, d, f, s;
    logic [7:0] ea[4] = '{8'hdf, 8'hde, 8'hdd, 8'hdc};
    logic [7:0] ed[4] = '{8'h80, 8'h80, 8'h00, 8'hff};
    logic [7:0] ef[4] = '{8'h2c, 8'h14, 8'h1b, 8'h35};
    load('{16'he70f, 16'he011, 16'h0f01, 16'h930f, 16'h0e00, 16'h920f,
           16'h0f00, 16'h930f, 16'h5012, 16'h931f}, 0);
    rst();
    for (int i = 0; i < 4; i++)
    begin
      wait_bus(1'b1, a, d, f, s);
      chk(a, ea[i]);
      chk(d, ed[i]);
      chk(f, ef[i]);
      chk(s, ea[i] - 8'h01);
    end
    $display("alu test done");
  endtask

  // pop then push, stack pointer read by io and by data-space pointer
  task automatic t_stack();
    logic [7:0] a, d, f, s;
    load('{16'hea00, 16'hbf0d, 16'h914f, 16'h934f, 16'hb75d, 16'h935f,
           16'he5ad, 16'he0b0, 16'h916c, 16'h936f}, 0);
    rst();
    mem_model_i.ram[8'ha1] = 8'h5a;
    wait_bus(1'b0, a, d, f, s);
    chk(a, 8'ha1);
    chk(s, 8'ha1);
    wait_bus(1'b1, a, d, f, s);
    chk(d, 8'h5a);
    chk(s, 8'ha0);
    wait_bus(1'b1, a, d, f, s);
    chk(d, 8'ha0);
    wait_bus(1'b1, a, d, f, s);
    chk(a, 8'h9f);
    chk(d, 8'h9f);
    $display("stack test done");
  endtask

  task automatic t_call();
    logic [7:0] a, d, f, s;
    load('{16'hec00, 16'hbf0d, 16'hd00d, 16'h930f}, 0);
    load('{16'h9508}, 16);
    rst();
    wait_bus(1'b1, a, d, f, s);
    chk(a, 8'hc0);
    chk(d, 8'h03);
    wait_bus(1'b1, a, d, f, s);
    chk(a, 8'hbf);
    chk(s, 8'hbe);
    wait_bus(1'b0, a, d, f, s);
    chk(a, 8'hbf);
    chk(s, 8'hc0);
    wait_bus(1'b1, a, d, f, s);
    chk(a, 8'hc0);
    chk(d, 8'hc0);
    $display("call test done");
  endtask

  // requests pending from reset; taken only after global enable
  task automatic t_irq();
    logic [7:0] a, d, f, s;
    load('{16'hc00f, 16'h0000, 16'h0000, 16'h9518}, 0);
    load('{16'hec00, 16'hbf0d, 16'h0000, 16'h9478, 16'h94f8, 16'h930f}, 16);
    ack_seen = 8'h00;
    rst();
    irq_req <= 8'h24;
    wait_bus(1'b1, a, d, f, s);
    chk(a, 8'hc0);
    chk(d, 8'h14);
    wait_bus(1'b1, a, d, f, s);
    chk(f & 8'h80, 8'h00);
    chk(ack_seen, 8'h04);
    for (int k = 0; k < 40 && status_flags_reg[7] !== 1'b1; k++) @(negedge clock);
    chk(status_flags_reg & 8'h80, 8'h80);
    wait_bus(1'b1, a, d, f, s);
    chk(a, 8'hc0);
    chk(f, 8'h00);
    $display("interrupt test done");
  endtask

  task automatic t_bits();
    logic [7:0] a, d, f, s;
    load('{16'he004, 16'hfb02, 16'hf917, 16'h931f}, 0);
    rst();
    wait_bus(1'b1, a, d, f, s);
    chk(d, 8'h80);
    chk(f, 8'h40);
    $display("bit copy test done");
  endtask

  // ----
  // run control
  // ----
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // all tests need well under 1000 cycles
  initial
  begin
    #100000;
    miscompares++;
    wrap_up();
  end

  initial
  begin
    t_reset();
    t_alu();
    t_stack();
    t_call();
    t_irq();
    t_bits();
    wrap_up();
  end
endmodule
